// ===== rtl/hss_pkg.sv
/*
  hss_pkg: constants and types for the home search sequencer.
  Assumes a 50 MHz system clock and a word-indexed register port.
*/
package hss_pkg;
  // register port geometry
  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;

  // register indices
  localparam logic [ADDR_W-1:0] REG_CTRL     = 4'h0;
  localparam logic [ADDR_W-1:0] REG_SPEED    = 4'h1;
  localparam logic [ADDR_W-1:0] REG_HALT_DEC = 4'h2;
  localparam logic [ADDR_W-1:0] REG_CMD      = 4'h3;
  localparam logic [ADDR_W-1:0] REG_STATUS   = 4'h4;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h5;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h6;

  // control bits: which inputs are in use
  localparam int CFG_HOME  = 0;
  localparam int CFG_CW    = 1;
  localparam int CFG_CCW   = 2;
  localparam int CFG_ESTOP = 3;
  localparam int CFG_W     = 4;

  // command bits
  localparam int CMD_CW    = 0;
  localparam int CMD_CCW   = 1;
  localparam int CMD_HOLD  = 2;
  localparam int CMD_ISTOP = 3;

  // event bits
  localparam int EV_DONE   = 0;
  localparam int EV_FAULT  = 1;
  localparam int EV_CMDERR = 2;
  localparam int EV_HALT   = 3;
  localparam int NUM_EV    = 4;

  // input bit positions
  localparam int IN_HOME  = 0;
  localparam int IN_CW    = 1;
  localparam int IN_CCW   = 2;
  localparam int IN_ESTOP = 3;
  localparam int NUM_IN   = 4;

  // status field positions
  localparam int ST_BUSY_BIT = 4;
  localparam int ST_DIR_BIT  = 5;
  localparam int ST_IN_LSB   = 8;

  // reset values
  localparam logic [CFG_W-1:0]  CTRL_RST  = 4'h0;
  localparam logic [DATA_W-1:0] SPEED_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DEC_RST   = 32'h0000_0000;
  localparam logic [NUM_EV-1:0] MASK_RST  = 4'h0;

  // timing
  localparam int CLK_HZ       = 50_000_000;
  localparam int PAUSE_MS     = 2000;
  localparam int PAUSE_CYCLES = PAUSE_MS * (CLK_HZ / 1000);
  localparam int CREEP_DIV    = 10;

  typedef enum logic [3:0] {
    ST_IDLE, ST_SEEK, ST_STOP1, ST_PAUSE1, ST_BACK,
    ST_STOP2, ST_PAUSE2, ST_CREEP, ST_FSTOP, ST_HOLD
  } hss_state_type;
endpackage : hss_pkg

// ===== rtl/hss_home_search.sv
/*
  hss_home_search: home search sequencer with register port, input
  synchronisers, event interrupt and profile generator handshake.
  Assumes a profile generator that ramps on move_run_out and reports
  rest on motion_stopped_in; raw inputs may be asynchronous.
*/
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
// Behaviour
// RQ1: three homing inputs: home sensor and two end-of-travel limits.
// RQ2: a search needs the home sensor configured; limits are optional.
// RQ3: counterclockwise search mirrors the clockwise profile exactly.
// RQ4: run ahead until home active, stop, pause two seconds.
// RQ5: run back until home goes inactive, stop, pause two seconds.
// RQ6: creep toward home at a tenth speed, stop on its rising edge.
// RQ7: home already active at start: begin with the run back.
// RQ8: limit ahead during first run: abrupt-rate stop, pause, then run back.
// RQ9: zero abrupt rate means a limit stop halts with no ramp.
// RQ10: limit ahead already active at start: begin with the run back.
// RQ11: opposite limit during a search: immediate stop and input fault.
// RQ12: hold aborts with a programmed-rate stop; no resume afterwards.
// RQ13: normal finish is a controlled stop with no error.
// RQ14: immediate stop command halts a search at once.
// RQ15: emergency stop input rising edge halts a search at once.
// RQ16: reaching home zeroes profile and encoder position.
// RQ17: inputs are synchronised and edge detected before use.
// RQ18: search without a home sensor is refused with an error flag.
module hss_home_search
  import hss_pkg::*;
#(
  parameter int unsigned PAUSE_CYC = PAUSE_CYCLES
)(
  // clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              resetn_in,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [DATA_W-1:0] reg_rdata_out,
  output logic                   irq_out,
  // homing inputs
  input  wire logic              home_sensor_in,
  input  wire logic              clockwise_travel_limit_in,
  input  wire logic              counterclockwise_travel_limit_in,
  input  wire logic              estop_in,
  // profile generator
  input  wire logic              motion_stopped_in,
  output logic                   move_run_out,
  output logic                   move_cw_out,
  output logic      [DATA_W-1:0] move_speed_out,
  output logic                   decel_abrupt_out,
  output logic      [DATA_W-1:0] halt_decel_out,
  output logic                   halt_now_out,
  output logic                   pos_zero_out
);

  // limit lying ahead of travel in the given direction
  function automatic logic lim_ahead(input logic cw, input logic cw_lim,
                                     input logic ccw_lim);
    lim_ahead = cw ? cw_lim : ccw_lim;
  endfunction : lim_ahead

  logic [CFG_W-1:0]  ctrl_q;
  logic [DATA_W-1:0] speed_q, halt_dec_q, pause_cnt_q;
  logic [NUM_EV-1:0] stat_q, mask_q, ev_set;
  logic [NUM_IN-1:0] raw_in, sync1_q, sync2_q, prev_q, rise, fall;
  logic              pause_done;
  hss_state_type     st_q, st_d;
  logic              cw_q, cw_d, abrupt_d, halt_d, zero_d;
  logic              cmd_wr, start_any, start_cw, hold_cmd, istop_cmd;
  logic              home_act, cw_lim, ccw_lim, fwd_lim, opp_lim;
  logic              estop_rise, busy, abort;

  // two-flop synchronisers and edge detect; raw inputs are asynchronous
  assign raw_in = {estop_in, counterclockwise_travel_limit_in,
                   clockwise_travel_limit_in, home_sensor_in}; // [RQ1]
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
    end else begin
      sync1_q <= raw_in;  // [RQ17]
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end
  assign rise = sync2_q & ~prev_q; // [RQ17]
  assign fall = ~sync2_q & prev_q;

  // qualified inputs; an unconfigured limit never stops the axis
  assign home_act   = sync2_q[IN_HOME];
  assign cw_lim     = sync2_q[IN_CW] & ctrl_q[CFG_CW];   // [RQ2]
  assign ccw_lim    = sync2_q[IN_CCW] & ctrl_q[CFG_CCW];
  assign estop_rise = rise[IN_ESTOP] & ctrl_q[CFG_ESTOP];
  assign fwd_lim    = lim_ahead(cw_q, cw_lim, ccw_lim);   // [RQ3]
  assign opp_lim    = lim_ahead(!cw_q, cw_lim, ccw_lim);

  // command decode; clockwise wins if both start bits are written
  assign cmd_wr    = reg_wr_in && (reg_addr_in == REG_CMD);
  assign start_any = cmd_wr && (reg_wdata_in[CMD_CW] ||
                                reg_wdata_in[CMD_CCW]);
  assign start_cw  = reg_wdata_in[CMD_CW];
  assign hold_cmd  = cmd_wr && reg_wdata_in[CMD_HOLD];
  assign istop_cmd = cmd_wr && reg_wdata_in[CMD_ISTOP];
  assign busy      = (st_q != ST_IDLE);
  assign abort     = busy && (istop_cmd || estop_rise || opp_lim);

  // configuration registers
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      ctrl_q     <= CTRL_RST;
      speed_q    <= SPEED_RST;
      halt_dec_q <= DEC_RST;
      mask_q     <= MASK_RST;
    end else if (reg_wr_in) begin
      if (reg_addr_in == REG_CTRL) begin
        ctrl_q <= reg_wdata_in[CFG_W-1:0];
      end else if (reg_addr_in == REG_SPEED) begin
        speed_q <= reg_wdata_in;
      end else if (reg_addr_in == REG_HALT_DEC) begin
        halt_dec_q <= reg_wdata_in;
      end else if (reg_addr_in == REG_IRQ_MASK) begin
        mask_q <= reg_wdata_in[NUM_EV-1:0];
      end
    end
  end

  // sequencer next state; aborts outrank hold, hold outranks the profile
  always_comb begin
    st_d     = st_q;
    cw_d     = cw_q;
    abrupt_d = decel_abrupt_out;
    halt_d   = 1'b0;
    zero_d   = 1'b0;
    ev_set   = '0;
    if (!busy) begin
      if (start_any) begin
        if (!ctrl_q[CFG_HOME]) begin
          ev_set[EV_CMDERR] = 1'b1; // [RQ18] [RQ2]
        end else begin
          cw_d     = start_cw;
          abrupt_d = 1'b0;
          if (home_act ||
              lim_ahead(start_cw, cw_lim, ccw_lim)) begin
            st_d = ST_BACK; // [RQ7] [RQ10]
          end else begin
            st_d = ST_SEEK; // [RQ4]
          end
        end
      end
    end else if (abort) begin
      st_d             = ST_IDLE; // [RQ14] [RQ15] [RQ11]
      halt_d           = 1'b1;
      ev_set[EV_HALT]  = 1'b1;
      ev_set[EV_FAULT] = opp_lim; // [RQ11]
    end else if (hold_cmd) begin
      st_d     = ST_HOLD; // [RQ12]
      abrupt_d = 1'b0;
    end else begin
      ev_set[EV_CMDERR] = start_any; // no restart while busy
      case (st_q)
        ST_SEEK: begin
          if (home_act) begin
            st_d = ST_STOP1; // [RQ4]
          end else if (fwd_lim) begin
            st_d     = ST_STOP1; // [RQ8]
            abrupt_d = 1'b1;
            halt_d   = (halt_dec_q == '0); // [RQ9]
          end
        end
        ST_STOP1: begin
          if (motion_stopped_in) begin
            st_d = ST_PAUSE1;
          end
        end
        ST_PAUSE1: begin
          if (pause_done) begin
            st_d     = ST_BACK; // [RQ5] [RQ8]
            abrupt_d = 1'b0;
          end
        end
        ST_BACK: begin
          if (fall[IN_HOME]) begin
            st_d = ST_STOP2; // [RQ5]
          end
        end
        ST_STOP2: begin
          if (motion_stopped_in) begin
            st_d = ST_PAUSE2;
          end
        end
        ST_PAUSE2: begin
          if (pause_done) begin
            st_d = ST_CREEP; // [RQ6]
          end
        end
        ST_CREEP: begin
          if (rise[IN_HOME]) begin
            st_d = ST_FSTOP; // [RQ6]
          end
        end
        ST_FSTOP: begin
          if (motion_stopped_in) begin
            st_d             = ST_IDLE; // [RQ13]
            zero_d           = 1'b1;    // [RQ16]
            ev_set[EV_DONE]  = 1'b1;
          end
        end
        ST_HOLD: begin
          if (motion_stopped_in) begin
            st_d = ST_IDLE; // [RQ12]
          end
        end
        default: begin
          st_d = ST_IDLE;
        end
      endcase
    end
  end

  // state and search direction
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      st_q <= ST_IDLE;
      cw_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cw_q <= cw_d;
    end
  end

  // pause timer; cleared outside pause states so each pause is full
  assign pause_done = (pause_cnt_q == 32'(PAUSE_CYC - 1)); // [RQ4]
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      pause_cnt_q <= '0;
    end else if ((st_q == ST_PAUSE1 || st_q == ST_PAUSE2) &&
                 !pause_done) begin
      pause_cnt_q <= pause_cnt_q + 32'h0000_0001;
    end else begin
      pause_cnt_q <= '0;
    end
  end

  // profile generator drive, registered from the next state
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      move_run_out     <= 1'b0;
      move_cw_out      <= 1'b0;
      move_speed_out   <= '0;
      decel_abrupt_out <= 1'b0;
      halt_now_out     <= 1'b0;
      pos_zero_out     <= 1'b0;
    end else begin
      move_run_out     <= (st_d == ST_SEEK) || (st_d == ST_BACK) ||
                          (st_d == ST_CREEP);
      // back-off legs run against the search direction
      move_cw_out      <= (st_d == ST_BACK || st_d == ST_STOP2 ||
                           st_d == ST_PAUSE2) ? !cw_d : cw_d; // [RQ3]
      move_speed_out   <= (st_d == ST_CREEP) ?
                          speed_q / DATA_W'(CREEP_DIV) : speed_q; // [RQ6]
      decel_abrupt_out <= abrupt_d; // [RQ8]
      halt_now_out     <= halt_d;
      pos_zero_out     <= zero_d; // [RQ16]
    end
  end
  assign halt_decel_out = halt_dec_q;

  // sticky events; a set in the clearing cycle survives the clear
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      stat_q <= '0;
    end else if (reg_wr_in && reg_addr_in == REG_IRQ_STAT) begin
      stat_q <= (stat_q & ~reg_wdata_in[NUM_EV-1:0]) | ev_set;
    end else begin
      stat_q <= stat_q | ev_set;
    end
  end
  assign irq_out = |(stat_q & mask_q);

  // read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in || !reg_rd_in) begin
      reg_rdata_out <= '0;
    end else if (reg_addr_in == REG_CTRL) begin
      reg_rdata_out <= DATA_W'(ctrl_q);
    end else if (reg_addr_in == REG_SPEED) begin
      reg_rdata_out <= speed_q;
    end else if (reg_addr_in == REG_HALT_DEC) begin
      reg_rdata_out <= halt_dec_q;
    end else if (reg_addr_in == REG_STATUS) begin
      reg_rdata_out <= DATA_W'({sync2_q, 2'h0, cw_q, busy, st_q});
    end else if (reg_addr_in == REG_IRQ_STAT) begin
      reg_rdata_out <= DATA_W'(stat_q);
    end else if (reg_addr_in == REG_IRQ_MASK) begin
      reg_rdata_out <= DATA_W'(mask_q);
    end else begin
      reg_rdata_out <= '0; // unmapped and write-only read zero
    end
  end

  chk_refuse_no_home: assert property ( // [RQ18]
    @(posedge sys_clk_in) disable iff (!resetn_in)
    (!busy && start_any && !ctrl_q[CFG_HOME])
      |=> (st_q == ST_IDLE) && stat_q[EV_CMDERR])
    else $error("search without home sensor not refused");
  chk_pause_full: assert property ( // [RQ4]
    @(posedge sys_clk_in) disable iff (!resetn_in)
    (st_q == ST_PAUSE1 && st_d == ST_BACK)
      |-> pause_cnt_q == 32'(PAUSE_CYC - 1))
    else $error("pause ended early");

  chk_start_home: assert property ( // [RQ7]
    @(posedge sys_clk_in) disable iff (!resetn_in)
    (!busy && start_any && ctrl_q[CFG_HOME] && home_act)
      |=> st_q == ST_BACK ##1 move_run_out && move_cw_out != cw_q)
    else $error("active home did not start with run back");
  chk_back_dir: assert property ( // [RQ5]
    @(posedge sys_clk_in) disable iff (!resetn_in)
    (st_q == ST_BACK) |=> !$stable(st_q) || move_cw_out == !cw_q)
    else $error("run back in wrong direction");

  chk_creep_speed: assert property ( // [RQ6]
    @(posedge sys_clk_in) disable iff (!resetn_in)
    (st_q == ST_CREEP && $past(st_q) == ST_CREEP)
      |-> move_speed_out == speed_q / DATA_W'(CREEP_DIV) &&
          move_cw_out == cw_q)
    else $error("creep speed or direction wrong");
  chk_limit_stop: assert property ( // [RQ8]
    @(posedge sys_clk_in) disable iff (!resetn_in)
    (st_q == ST_SEEK && !abort && !hold_cmd && !home_act && fwd_lim)
      |=> st_q == ST_STOP1 && decel_abrupt_out && !move_run_out)
    else $error("limit ahead not stopped abruptly");

  chk_zero_halt: assert property ( // [RQ9]
    @(posedge sys_clk_in) disable iff (!resetn_in)
    (st_q == ST_SEEK && st_d == ST_STOP1 && fwd_lim && !home_act &&
     halt_dec_q == '0) |=> halt_now_out)
    else $error("zero abrupt rate gave no instant halt");
  chk_opp_fault: assert property ( // [RQ11]
    @(posedge sys_clk_in) disable iff (!resetn_in)
    (busy && opp_lim)
      |=> st_q == ST_IDLE && halt_now_out && stat_q[EV_FAULT])
    else $error("opposite limit did not fault");

  chk_hold_stop: assert property ( // [RQ12]
    @(posedge sys_clk_in) disable iff (!resetn_in)
    (busy && hold_cmd && !abort)
      |=> st_q == ST_HOLD && !decel_abrupt_out && !move_run_out)
    else $error("hold did not start a controlled stop");
  chk_estop_halt: assert property ( // [RQ15]
    @(posedge sys_clk_in) disable iff (!resetn_in)
    (busy && estop_rise) |=> st_q == ST_IDLE ##0 halt_now_out)
    else $error("emergency stop did not halt");

  chk_done_zero: assert property ( // [RQ16]
    @(posedge sys_clk_in) disable iff (!resetn_in)
    $rose(pos_zero_out) |-> stat_q[EV_DONE] && st_q == ST_IDLE &&
      $past(st_q) == ST_FSTOP ##1 !pos_zero_out)
    else $error("home zero pulse malformed");

endmodule : hss_home_search

// ===== bench/hss_motor_model.sv
/*
  hss_motor_model: stand-in for the profile generator that sits beyond
  the sequencer. Assumes run and halt levels on the sequencer's clock.
*/
`timescale 1ns/1ps
module hss_motor_model (
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       resetn_in,
  // sequencer side
  input  wire logic       run_in,
  input  wire logic       halt_in,
  input  wire logic [3:0] delay_in,
  output logic            stopped_out
);
  logic [3:0] ramp_q;

  // ramp down over delay_in cycles; a halt cuts the ramp short
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      ramp_q      <= 4'h0;
      stopped_out <= 1'b1;
    end else if (run_in) begin
      ramp_q      <= 4'h0;
      stopped_out <= 1'b0;
    end else if (halt_in || ramp_q >= delay_in) begin
      stopped_out <= 1'b1;
    end else begin
      ramp_q <= ramp_q + 4'h1;
    end
  end
endmodule : hss_motor_model

// ===== bench/hss_home_search_bench.sv
/*
  hss_home_search_bench: self-checking bench for the home search sequencer.
  Assumes the motor model in its own file and a 20-cycle pause.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %0h want %0h", $time, (g), (e)); end end
module hss_home_search_bench;
  import hss_pkg::*;
  localparam int PAUSE = 20;
  logic              clk, resetn, wr, rd, irq, home, cw_lim, ccw_lim;
  logic              estop, stopped, run, dir_cw, abrupt, halt, zero;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, speed, hdec, st;
  logic [3:0]        dly;
  int                n_errors, n_checks, n_halt, n_zero;

  hss_home_search #(.PAUSE_CYC(PAUSE)) hss_home_search_inst (
    .sys_clk_in(clk), .resetn_in(resetn), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .irq_out(irq), .home_sensor_in(home),
    .clockwise_travel_limit_in(cw_lim),
    .counterclockwise_travel_limit_in(ccw_lim), .estop_in(estop),
    .motion_stopped_in(stopped), .move_run_out(run), .move_cw_out(dir_cw),
    .move_speed_out(speed), .decel_abrupt_out(abrupt),
    .halt_decel_out(hdec), .halt_now_out(halt), .pos_zero_out(zero));

  hss_motor_model hss_motor_model_inst (
    .sys_clk_in(clk), .resetn_in(resetn), .run_in(run), .halt_in(halt),
    .delay_in(dly), .stopped_out(stopped));

  // free-running 50 MHz clock
  always #10 clk = ~clk;

  // pulse counters, sampled a cycle after each pulse lands
  always @(posedge clk) begin
    if (halt === 1'b1) n_halt++;
    if (zero === 1'b1) n_zero++;
  end

  task automatic complete_run;
    if (n_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  task automatic idle(input int k);
    repeat (k) @(posedge clk);
  endtask : idle

  task automatic wr_reg(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [ADDR_W-1:0] a,
                        output logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  // bounded wait for the run level; n counts cycles spent
  task automatic wait_run(input logic lvl, output int n);
    n = 0;
    #1; // let the launching edge settle before looking at run
    while (run !== lvl) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 400) begin
        n_errors++;
        $display("unexpected at %0t: run level never came", $time);
        complete_run();
      end
    end
  endtask : wait_run

  // mode 0 plain, 1 home on at start, 2 limit ahead on, 3 limit in seek
  task automatic search(input logic cw, input int mode);
    logic [DATA_W-1:0] spd, dec;
    int                n, h0, z0;
    spd = $urandom_range(100000, 10);
    dec = cw ? 32'h0 : $urandom_range(500, 1);
    dly <= 4'($urandom_range(8, 1));
    wr_reg(REG_SPEED, spd);
    wr_reg(REG_HALT_DEC, dec);
    home <= (mode == 1);
    if (cw) cw_lim <= (mode == 2);
    else ccw_lim <= (mode == 2);
    idle(4);
    h0 = n_halt;
    z0 = n_zero;
    wr_reg(REG_CMD, cw ? 32'h1 : 32'h2);
    if (mode == 0 || mode == 3) begin
      wait_run(1'b1, n);
      `CHK({dir_cw, speed}, {cw, spd})
      if (mode == 0) home <= 1'b1;
      else if (cw) cw_lim <= 1'b1;
      else ccw_lim <= 1'b1;
      wait_run(1'b0, n);
      `CHK(abrupt, 1'(mode == 3))
      idle(2);
      `CHK(n_halt - h0, int'(mode == 3 && dec == 0))
      `CHK(hdec, dec)
    end
    wait_run(1'b1, n);
    `CHK(n >= PAUSE || mode == 1 || mode == 2, 1'b1)
    `CHK({dir_cw, speed}, {~cw, spd})
    cw_lim  <= 1'b0;
    ccw_lim <= 1'b0;
    home    <= 1'b1;
    idle(4);
    home <= 1'b0;
    wait_run(1'b0, n);
    wait_run(1'b1, n);
    `CHK(n >= PAUSE, 1'b1)
    `CHK({dir_cw, speed}, {cw, spd / CREEP_DIV})
    home <= 1'b1;
    wait_run(1'b0, n);
    repeat (60) if (n_zero == z0) @(posedge clk);
    `CHK(n_zero - z0, 1)
    rd_reg(REG_IRQ_STAT, st);
    `CHK(st, 32'h1)
    wr_reg(REG_IRQ_STAT, 32'hF);
    home <= 1'b0;
    idle(4);
  endtask : search

  // kind 0 hold, 1 stop command, 2 emergency input, 3 opposite limit
  task automatic abort(input int kind);
    int n, h0;
    h0 = n_halt;
    wr_reg(REG_CMD, 32'h1);
    wait_run(1'b1, n);
    case (kind)
      0: wr_reg(REG_CMD, 32'h4);
      1: wr_reg(REG_CMD, 32'h8);
      2: estop <= 1'b1;
      default: ccw_lim <= 1'b1;
    endcase
    wait_run(1'b0, n);
    if (kind == 0) `CHK(abrupt, 1'b0)
    idle(2);
    `CHK(n_halt - h0, int'(kind != 0))
    idle(3 * PAUSE);
    `CHK(run, 1'b0)
    rd_reg(REG_STATUS, st);
    `CHK(st[ST_BUSY_BIT], 1'b0)
    rd_reg(REG_IRQ_STAT, st);
    `CHK(st, kind == 0 ? 32'h0 : kind == 3 ? 32'hA : 32'h8)
    `CHK(irq, 1'(kind != 0))
    estop   <= 1'b0;
    ccw_lim <= 1'b0;
    wr_reg(REG_IRQ_STAT, 32'hF);
    idle(1);
    `CHK(irq, 1'b0)
  endtask : abort

  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    $display("unexpected at %0t: run too long", $time);
    complete_run();
  end

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    {wr, rd, home, cw_lim, ccw_lim, estop} = 6'h0;
    addr = 4'h0;
    wdata = 32'h0;
    dly = 4'h2;
    void'($urandom(32'h5850A1FF));
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    // every index, mapped or not, reads zero after reset
    for (int a = 0; a < 16; a++) begin
      rd_reg(4'(a), st);
      `CHK(st, 32'h0)
    end
    // search refused while no home sensor is configured
    wr_reg(REG_CMD, 32'h1);
    idle(3);
    `CHK(run, 1'b0)
    rd_reg(REG_IRQ_STAT, st);
    `CHK(st, 32'h4)
    `CHK(irq, 1'b0)
    wr_reg(REG_IRQ_MASK, 32'h4);
    idle(1);
    `CHK(irq, 1'b1)
    wr_reg(REG_IRQ_STAT, 32'h4);
    idle(1);
    `CHK(irq, 1'b0)
    wr_reg(REG_CTRL, 32'hF);
    rd_reg(REG_CTRL, st);
    `CHK(st, 32'hF)
    wr_reg(REG_IRQ_MASK, 32'hF);
    for (int d = 1; d >= 0; d--)
      for (int m = 0; m < 4; m++)
        search(d[0], m);
    for (int k = 0; k < 4; k++)
      abort(k);
    complete_run();
  end
endmodule : hss_home_search_bench
